// ### verilog/dcd_params.svh
// Opcode patterns, cycle counts and selector codes for the opcode decoder.
`ifndef DCD_PARAMS_SVH
`define DCD_PARAMS_SVH
`define DCD_HB_MULT_ACCUM 8'ha2
`define DCD_HB_MULT_ACCUM_MOVE 8'ha3
`define DCD_HB_MULTIPLY 8'h54
`define DCD_HB_UNS_MULTIPLY 8'h55
`define DCD_HB_MULT_ADD_PREV 8'h50
`define DCD_HB_MULT_SUB_PREV 8'h51
`define DCD_HB_SQUARE_ADD 8'h52
`define DCD_HB_SQUARE_SUB 8'h53
`define DCD_OP_PROD_TO_ACCUM 16'hbe03
`define DCD_OP_SUB_PROD 16'hbe05
`define DCD_HB_STORE_PROD_HI 8'h8d
`define DCD_HB_STORE_PROD_LO 8'h8c
`define DCD_SHIFT_SET_TOP 14'h2fc0
`define DCD_HB_BRANCH_AR_NZ 8'h7b
`define DCD_OP_BRANCH_ACCUM 16'hbe20
`define DCD_OP_CALL_ACCUM 16'hbe30
`define DCD_COND_BRANCH_TOP 6'h38
`define DCD_COND_CALL_TOP 6'h3a
`define DCD_COND_RET_TOP 6'h3b
`define DCD_BIT_TOP 4'h4
`define DCD_HB_TEMP_BIT_TEST 8'h6f
`define DCD_HB_PAGE_LOAD 8'h0d
`define DCD_PAGE_LOAD_K_TOP 7'h5e
`define DCD_HB_STATUS0_LOAD 8'h0e
`define DCD_HB_STATUS1_LOAD 8'h0f
`define DCD_HB_STATUS0_STORE 8'h8e
`define DCD_HB_STATUS1_STORE 8'h8f
`define DCD_OP_POP 16'hbe32
`define DCD_OP_PUSH 16'hbe3c
`define DCD_HB_POP_MEM 8'h8a
`define DCD_HB_PUSH_MEM 8'h76
`define DCD_HB_REPEAT_MEM 8'h0b
`define DCD_HB_REPEAT_K 8'hbb
`define DCD_HB_BLOCK_SRC 8'ha8
`define DCD_HB_BLOCK_DST 8'ha9
`define DCD_HB_BLOCK_PROG 8'ha5
`define DCD_HB_TABLE_READ 8'ha6
`define DCD_HB_TABLE_WRITE 8'ha7
`define DCD_HB_PORT_IN 8'haf
`define DCD_HB_PORT_OUT 8'h0c
`define DCD_MULT_K_TOP 3'h6
`define DCD_CYC_TAKEN 4'h4
`define DCD_CYC_NOT 4'h2
`define DCD_SEL_PIN 2'h0
`define DCD_SEL_TCSET 2'h1
`define DCD_SEL_TCCLR 2'h2
`endif

// ### verilog/dcd_pkg.sv
// Types shared by the opcode decoder.
`default_nettype none
package dcd_pkg;
  typedef enum logic [5:0] {
    OP_NONE, OP_MULT_ACCUM, OP_MULT_ACCUM_MOVE, OP_MULTIPLY, OP_MULTIPLY_K,
    OP_UNSIGNED_MULTIPLY, OP_MULTIPLY_ADD_PREV, OP_MULTIPLY_SUB_PREV,
    OP_SQUARE_ADD_PREV, OP_SQUARE_SUB_PREV, OP_PRODUCT_TO_ACCUM,
    OP_SUB_PRODUCT, OP_STORE_PRODUCT_HIGH, OP_STORE_PRODUCT_LOW,
    OP_SET_PRODUCT_SHIFT, OP_BRANCH_AR_NONZERO, OP_BRANCH_TO_ACCUM,
    OP_CALL_TO_ACCUM, OP_COND_BRANCH, OP_COND_CALL, OP_COND_RETURN,
    OP_BIT_TEST, OP_TEMP_BIT_TEST, OP_LOAD_PAGE_PTR, OP_LOAD_PAGE_PTR_K,
    OP_LOAD_STATUS0, OP_LOAD_STATUS1, OP_STORE_STATUS0, OP_STORE_STATUS1,
    OP_STACK_POP_ACCUM, OP_STACK_PUSH_ACCUM, OP_STACK_POP_MEM,
    OP_STACK_PUSH_MEM, OP_REPEAT_NEXT, OP_REPEAT_NEXT_K,
    OP_DATA_BLOCK_MOVE_SRC, OP_DATA_BLOCK_MOVE_DST, OP_PROG_BLOCK_MOVE,
    OP_TABLE_READ, OP_TABLE_WRITE, OP_IO_IN, OP_IO_OUT
  } dcd_op_type;
  typedef enum logic [1:0] {ST_IDLE, ST_WORD2, ST_EXEC} dcd_state_type;
endpackage
`default_nettype wire

// ### verilog/dcd_opcode_decoder.sv
// Instruction decoder fixing operation, word length and cycle count.
// Functional notes
// - Accumulating multiplies, high bytes a2/a3: two words, three cycles.
// - Signed and unsigned memory multiply: one word, one cycle.
// - Top bits 110: immediate multiply with 13-bit constant, one cycle.
// - Multiply add/sub previous product, one word, one cycle.
// - Square add/sub previous product, one word, one cycle.
// - Product load to and subtract from accumulator, one cycle.
// - Store product upper and lower half, one word, one cycle.
// - Product shift set copies its 2-bit field to status one.
// - Branch on aux nonzero: two words, 4 taken, 2 not taken.
// - Branch and call to accumulator address, one word, 4 cycles.
// - Conditional branch, call, return: 4 if all hold, else 2.
// - Bit test by 4-bit code, and temporary-register bit test.
// - Page pointer load, memory or 9-bit immediate, 2 cycles.
// - Status register zero and one loads take 2 cycles.
// - Status register zero and one stores take one cycle.
// - Pop to and push from low accumulator, one cycle.
// - Stack pop to memory and push from memory, one cycle.
// - Repeat next with count from memory or short immediate.
// - Repeat runs the next instruction count plus one times.
// - Data block moves with long source or destination, 2 words, 3 cycles.
// - Program block move 2 words; table read and write 3 cycles.
// - Port input 2 words 2 cycles; output 2 words 3 cycles.
// - Selector: 00 pin low, 01 flag set, 10 flag clear, 11 none.
// - Low nibble masks tested flags; high nibble gives required state.
// - Operand byte top bit: 0 direct page offset, 1 indirect.
// - Short page pointer load carries a 9-bit constant.
`include "dcd_params.svh"
`default_nettype none
module dcd_opcode_decoder
  import dcd_pkg::*;
(
  // Clock and reset.
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  // Fetch side.
  input wire logic WORD_VALID_IN,
  input wire logic [15:0] WORD_IN,
  input wire logic WAIT_IN,
  // Condition and repeat-count inputs.
  input wire logic BRANCH_INPUT_PIN_IN,
  input wire logic TEST_CONTROL_FLAG_IN,
  input wire logic [3:0] STATUS_FLAGS_IN,
  input wire logic AR_NONZERO_IN,
  input wire logic [15:0] REPEAT_MEM_COUNT_IN,
  // Decoded outputs.
  output logic READY_OUT,
  output logic DECODE_VALID_OUT,
  output logic [5:0] OP_OUT,
  output logic [1:0] WORDS_OUT,
  output logic [3:0] CYCLES_OUT,
  output logic [15:0] OPCODE_OUT,
  output logic [15:0] SECOND_WORD_OUT,
  output logic INDIRECT_OUT,
  output logic [6:0] DIRECT_OFFSET_OUT,
  output logic [12:0] IMMEDIATE_OUT,
  output logic [3:0] BIT_SELECT_CODE_OUT,
  output logic COND_TRUE_OUT,
  output logic PRODUCT_SHIFT_WE_OUT,
  output logic [1:0] PRODUCT_SHIFT_MODE_OUT,
  output logic [16:0] REPEAT_TOTAL_OUT,
  output logic EXEC_DONE_OUT
);
  typedef struct packed {
    dcd_state_type st;
    dcd_op_type op;
    logic [1:0] words;
    logic [3:0] cycles;
    logic [3:0] cnt;
    logic [15:0] opc;
    logic [15:0] w2;
    logic dv;
    logic cond;
    logic shift_we;
    logic [12:0] imm;
    logic rdy;
    logic [16:0] repeat_next_op;
    logic done;
  } dcd_regs_type;

  dcd_regs_type r_q, r_d;

  dcd_op_type dec_op;
  logic [1:0] dec_words;
  logic [3:0] dec_cyc;
  logic dec_cond;
  logic [7:0] hb;
  logic sel_ok;
  logic flag_ok;
  logic all_ok;

  assign hb = WORD_IN[15:8];

  // Condition evaluation uses the live flags at the first word.
  always_comb begin
    case (WORD_IN[9:8])
      `DCD_SEL_PIN: sel_ok = ~BRANCH_INPUT_PIN_IN;
      `DCD_SEL_TCSET: sel_ok = TEST_CONTROL_FLAG_IN;
      `DCD_SEL_TCCLR: sel_ok = ~TEST_CONTROL_FLAG_IN;
      default: sel_ok = 1'b1;
    endcase
    flag_ok = ((STATUS_FLAGS_IN ^ WORD_IN[7:4]) & WORD_IN[3:0]) == 4'h0;
    all_ok = sel_ok & flag_ok;
  end

  always_comb begin
    dec_op = OP_NONE;
    dec_words = 2'd1;
    dec_cyc = 4'd1;
    dec_cond = 1'b1;
    if (WORD_IN[15:13] == `DCD_MULT_K_TOP) begin
      dec_op = OP_MULTIPLY_K;
    end else if (WORD_IN[15:10] == `DCD_COND_BRANCH_TOP) begin
      dec_op = OP_COND_BRANCH;
      dec_words = 2'd2;
      dec_cond = all_ok;
      dec_cyc = all_ok ? `DCD_CYC_TAKEN : `DCD_CYC_NOT;
    end else if (WORD_IN[15:10] == `DCD_COND_CALL_TOP) begin
      dec_op = OP_COND_CALL;
      dec_words = 2'd2;
      dec_cond = all_ok;
      dec_cyc = all_ok ? `DCD_CYC_TAKEN : `DCD_CYC_NOT;
    end else if (WORD_IN[15:10] == `DCD_COND_RET_TOP) begin
      dec_op = OP_COND_RETURN;
      dec_cond = all_ok;
      dec_cyc = all_ok ? `DCD_CYC_TAKEN : `DCD_CYC_NOT;
    end else if (WORD_IN[15:12] == `DCD_BIT_TOP) begin
      dec_op = OP_BIT_TEST;
    end else if (WORD_IN[15:9] == `DCD_PAGE_LOAD_K_TOP) begin
      dec_op = OP_LOAD_PAGE_PTR_K;
      dec_cyc = 4'd2;
    end else if (WORD_IN[15:2] == `DCD_SHIFT_SET_TOP) begin
      dec_op = OP_SET_PRODUCT_SHIFT;
    end else if (WORD_IN == `DCD_OP_PROD_TO_ACCUM) begin
      dec_op = OP_PRODUCT_TO_ACCUM;
    end else if (WORD_IN == `DCD_OP_SUB_PROD) begin
      dec_op = OP_SUB_PRODUCT;
    end else if (WORD_IN == `DCD_OP_BRANCH_ACCUM) begin
      dec_op = OP_BRANCH_TO_ACCUM;
      dec_cyc = 4'd4;
    end else if (WORD_IN == `DCD_OP_CALL_ACCUM) begin
      dec_op = OP_CALL_TO_ACCUM;
      dec_cyc = 4'd4;
    end else if (WORD_IN == `DCD_OP_POP) begin
      dec_op = OP_STACK_POP_ACCUM;
    end else if (WORD_IN == `DCD_OP_PUSH) begin
      dec_op = OP_STACK_PUSH_ACCUM;
    end else begin
      case (hb)
        `DCD_HB_MULT_ACCUM: begin
          dec_op = OP_MULT_ACCUM;
          dec_words = 2'd2;
          dec_cyc = 4'd3;
        end
        `DCD_HB_MULT_ACCUM_MOVE: begin
          dec_op = OP_MULT_ACCUM_MOVE;
          dec_words = 2'd2;
          dec_cyc = 4'd3;
        end
        `DCD_HB_MULTIPLY: dec_op = OP_MULTIPLY;
        `DCD_HB_UNS_MULTIPLY: dec_op = OP_UNSIGNED_MULTIPLY;
        `DCD_HB_MULT_ADD_PREV: dec_op = OP_MULTIPLY_ADD_PREV;
        `DCD_HB_MULT_SUB_PREV: dec_op = OP_MULTIPLY_SUB_PREV;
        `DCD_HB_SQUARE_ADD: dec_op = OP_SQUARE_ADD_PREV;
        `DCD_HB_SQUARE_SUB: dec_op = OP_SQUARE_SUB_PREV;
        `DCD_HB_STORE_PROD_HI: dec_op = OP_STORE_PRODUCT_HIGH;
        `DCD_HB_STORE_PROD_LO: dec_op = OP_STORE_PRODUCT_LOW;
        `DCD_HB_BRANCH_AR_NZ: begin
          if (WORD_IN[7]) begin
            dec_op = OP_BRANCH_AR_NONZERO;
            dec_words = 2'd2;
            dec_cond = AR_NONZERO_IN;
            dec_cyc = AR_NONZERO_IN ? `DCD_CYC_TAKEN : `DCD_CYC_NOT;
          end
        end
        `DCD_HB_TEMP_BIT_TEST: dec_op = OP_TEMP_BIT_TEST;
        `DCD_HB_PAGE_LOAD: begin
          dec_op = OP_LOAD_PAGE_PTR;
          dec_cyc = 4'd2;
        end
        `DCD_HB_STATUS0_LOAD: begin
          dec_op = OP_LOAD_STATUS0;
          dec_cyc = 4'd2;
        end
        `DCD_HB_STATUS1_LOAD: begin
          dec_op = OP_LOAD_STATUS1;
          dec_cyc = 4'd2;
        end
        `DCD_HB_STATUS0_STORE: dec_op = OP_STORE_STATUS0;
        `DCD_HB_STATUS1_STORE: dec_op = OP_STORE_STATUS1;
        `DCD_HB_POP_MEM: dec_op = OP_STACK_POP_MEM;
        `DCD_HB_PUSH_MEM: dec_op = OP_STACK_PUSH_MEM;
        `DCD_HB_REPEAT_MEM: dec_op = OP_REPEAT_NEXT;
        `DCD_HB_REPEAT_K: dec_op = OP_REPEAT_NEXT_K;
        `DCD_HB_BLOCK_SRC, `DCD_HB_BLOCK_DST, `DCD_HB_BLOCK_PROG: begin
          dec_op = (hb == `DCD_HB_BLOCK_SRC) ? OP_DATA_BLOCK_MOVE_SRC :
                   (hb == `DCD_HB_BLOCK_DST) ? OP_DATA_BLOCK_MOVE_DST :
                   OP_PROG_BLOCK_MOVE;
          dec_words = 2'd2;
          dec_cyc = 4'd3;
        end
        `DCD_HB_TABLE_READ: begin
          dec_op = OP_TABLE_READ;
          dec_cyc = 4'd3;
        end
        `DCD_HB_TABLE_WRITE: begin
          dec_op = OP_TABLE_WRITE;
          dec_cyc = 4'd3;
        end
        `DCD_HB_PORT_IN: begin
          dec_op = OP_IO_IN;
          dec_words = 2'd2;
          dec_cyc = 4'd2;
        end
        `DCD_HB_PORT_OUT: begin
          dec_op = OP_IO_OUT;
          dec_words = 2'd2;
          dec_cyc = 4'd3;
        end
        default: dec_op = OP_NONE;
      endcase
    end
  end

  // One instruction is held at a time; the fetch side waits on READY_OUT.
  always_comb begin
    r_d = r_q;
    r_d.dv = 1'b0;
    r_d.shift_we = 1'b0;
    r_d.done = 1'b0;
    case (r_q.st)
      ST_IDLE: begin
        if (WORD_VALID_IN) begin
          r_d.op = dec_op;
          r_d.words = dec_words;
          r_d.cycles = dec_cyc;
          // Unconditional operations report a true condition.
          r_d.cond = dec_cond;
          r_d.imm = (dec_op == OP_LOAD_PAGE_PTR_K) ?
                    {4'h0, WORD_IN[8:0]} : WORD_IN[12:0];
          r_d.opc = WORD_IN;
          r_d.w2 = 16'h0000;
          r_d.cnt = 4'd1;
          if (dec_op == OP_REPEAT_NEXT_K) begin
            r_d.repeat_next_op = {9'h000, WORD_IN[7:0]} + 17'h00001;
          end else if (dec_op == OP_REPEAT_NEXT) begin
            r_d.repeat_next_op = {1'b0, REPEAT_MEM_COUNT_IN} + 17'h00001;
          end
          if (dec_words == 2'd2) begin
            r_d.st = ST_WORD2;
          end else begin
            r_d.dv = 1'b1;
            r_d.shift_we = (dec_op == OP_SET_PRODUCT_SHIFT);
            r_d.st = ST_EXEC;
          end
        end
      end
      ST_WORD2: begin
        if (WORD_VALID_IN) begin
          r_d.w2 = WORD_IN;
          r_d.dv = 1'b1;
          r_d.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // A wait state stalls the count without changing the operation.
        if (!WAIT_IN) begin
          if (r_q.cnt >= r_q.cycles) begin
            r_d.done = 1'b1;
            r_d.st = ST_IDLE;
          end else begin
            r_d.cnt = r_q.cnt + 4'd1;
          end
        end
      end
      default: r_d.st = ST_IDLE;
    endcase
    r_d.rdy = (r_d.st != ST_EXEC);
    if (SRST_IN) begin
      r_d = '0;
      r_d.st = ST_IDLE;
      r_d.op = OP_NONE;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    r_q <= r_d;
  end

  // Outputs are all register fields or direct slices of registered words.
  assign READY_OUT = r_q.rdy;
  assign DECODE_VALID_OUT = r_q.dv;
  assign OP_OUT = r_q.op;
  assign WORDS_OUT = r_q.words;
  assign CYCLES_OUT = r_q.cycles;
  assign OPCODE_OUT = r_q.opc;
  assign SECOND_WORD_OUT = r_q.w2;
  assign INDIRECT_OUT = r_q.opc[7];
  assign DIRECT_OFFSET_OUT = r_q.opc[6:0];
  assign IMMEDIATE_OUT = r_q.imm;
  assign BIT_SELECT_CODE_OUT = r_q.opc[11:8];
  assign COND_TRUE_OUT = r_q.cond;
  assign PRODUCT_SHIFT_WE_OUT = r_q.shift_we;
  assign PRODUCT_SHIFT_MODE_OUT = r_q.opc[1:0];
  assign REPEAT_TOTAL_OUT = r_q.repeat_next_op;
  assign EXEC_DONE_OUT = r_q.done;

  property p_two_word_wait;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    (r_q.st == ST_IDLE && WORD_VALID_IN && dec_words == 2'd2)
      |=> !DECODE_VALID_OUT;
  endproperty
  a_two_word_wait: assert property (p_two_word_wait)
    else $error("Two-word instruction signalled before second word.");

  property p_mult_accum_len;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    (r_q.st == ST_IDLE && WORD_VALID_IN && hb == `DCD_HB_MULT_ACCUM)
      |=> (WORDS_OUT == 2'd2 && CYCLES_OUT == 4'd3);
  endproperty
  a_mult_accum_len: assert property (p_mult_accum_len)
    else $error("Accumulating multiply has wrong length.");

  property p_mult_k;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    (r_q.st == ST_IDLE && WORD_VALID_IN && WORD_IN[15:13] == 3'h6)
      |=> (OP_OUT == OP_MULTIPLY_K && CYCLES_OUT == 4'd1);
  endproperty
  a_mult_k: assert property (p_mult_k)
    else $error("Immediate multiply misdecoded.");

  property p_shift_we;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    PRODUCT_SHIFT_WE_OUT |-> (OP_OUT == OP_SET_PRODUCT_SHIFT);
  endproperty
  a_shift_we: assert property (p_shift_we)
    else $error("Product shift write without its instruction.");

  property p_cond_cycles;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    (r_q.st == ST_IDLE && WORD_VALID_IN && WORD_IN[15:10] == 6'h3b)
      |=> (CYCLES_OUT == (($past(all_ok)) ? 4'd4 : 4'd2));
  endproperty
  a_cond_cycles: assert property (p_cond_cycles)
    else $error("Conditional return cycle count wrong.");

  property p_repeat_k;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    (r_q.st == ST_IDLE && WORD_VALID_IN && hb == `DCD_HB_REPEAT_K)
      |=> (REPEAT_TOTAL_OUT == {9'h000, $past(WORD_IN[7:0])} + 17'h1);
  endproperty
  a_repeat_k: assert property (p_repeat_k)
    else $error("Repeat total is not count plus one.");

  property p_wait_hold;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    (r_q.st == ST_EXEC && WAIT_IN) |=> ($stable(r_q.cnt) && !EXEC_DONE_OUT);
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("Execution advanced during a wait state.");

  property p_one_cycle_done;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    (DECODE_VALID_OUT && CYCLES_OUT == 4'd1 && !WAIT_IN) |=> EXEC_DONE_OUT;
  endproperty
  a_one_cycle_done: assert property (p_one_cycle_done)
    else $error("One-cycle instruction did not finish.");

  property p_out_cycles;
    @(posedge SYS_CLK_IN) disable iff (SRST_IN)
    (r_q.st == ST_IDLE && WORD_VALID_IN && hb == `DCD_HB_PORT_OUT)
      |=> (CYCLES_OUT == 4'd3 && WORDS_OUT == 2'd2);
  endproperty
  a_out_cycles: assert property (p_out_cycles)
    else $error("Port output misdecoded.");

  c_two_word: cover property (@(posedge SYS_CLK_IN)
    DECODE_VALID_OUT && WORDS_OUT == 2'd2);
  c_taken: cover property (@(posedge SYS_CLK_IN)
    DECODE_VALID_OUT && OP_OUT == OP_COND_BRANCH && CYCLES_OUT == 4'd4);
  c_shift_set: cover property (@(posedge SYS_CLK_IN) PRODUCT_SHIFT_WE_OUT);
  c_wait: cover property (@(posedge SYS_CLK_IN)
    r_q.st == ST_EXEC && WAIT_IN);
endmodule
`default_nettype wire

// ### dv/dcd_fetch_model.sv
// Fetch-unit model that hands instruction words to the decoder.
`default_nettype none
module dcd_fetch_model (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Requests from the bench.
  input wire logic req_in,
  input wire logic slow_in,
  input wire logic [1:0] nwords_in,
  input wire logic [15:0] word1_in,
  input wire logic [15:0] word2_in,
  // Decoder side.
  input wire logic ready_in,
  output logic valid_out,
  output logic [15:0] word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic gap;
  logic second;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_out <= 1'b0;
      word_out <= 16'h0000;
      busy <= 1'b0;
      gap <= 1'b0;
      second <= 1'b0;
    end else if (!busy) begin
      if (req_in) begin
        busy <= 1'b1;
        valid_out <= 1'b1;
        word_out <= word1_in;
        second <= 1'b0;
      end
    end else if (gap) begin
      gap <= 1'b0;
      valid_out <= 1'b1;
      word_out <= word2_in;
    end else if (valid_out && ready_in) begin
      // Once a word is taken and valid drops, the bus shows its inverse, so a stale word
      // can never pass for fresh data.
      if (!second && nwords_in == 2'h2) begin
        second <= 1'b1;
        if (slow_in) begin
          gap <= 1'b1;
          valid_out <= 1'b0;
          word_out <= ~word_out;
        end else begin
          word_out <= word2_in;
        end
      end else begin
        busy <= 1'b0;
        valid_out <= 1'b0;
        word_out <= ~word_out;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/dsp_core_opcode_decoder_ext_tb.sv
// Self-checking bench for the opcode decoder with a fetch-unit model.
`default_nettype none
module dsp_core_opcode_decoder_ext_tb import dcd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, f_req, f_slow, wait_st, pin, tc, ar_nz, word_valid;
  logic [1:0] f_nw, words_o, psm;
  logic [15:0] f_w1, f_w2, word, rpt_cnt, opc_o, w2_o;
  logic [3:0] flags, cyc_o, bsel;
  logic rdy, dv, ind_o, ctrue, pswe, done;
  logic [5:0] op_o;
  logic [6:0] off_o;
  logic [12:0] imm_o;
  logic [16:0] rtot;
  int miscompares = 0;
  int checks_done = 0;

  dcd_opcode_decoder u_dcd_opcode_decoder (
    .SYS_CLK_IN(clk), .SRST_IN(srst), .WORD_VALID_IN(word_valid),
    .WORD_IN(word), .WAIT_IN(wait_st), .BRANCH_INPUT_PIN_IN(pin),
    .TEST_CONTROL_FLAG_IN(tc), .STATUS_FLAGS_IN(flags),
    .AR_NONZERO_IN(ar_nz), .REPEAT_MEM_COUNT_IN(rpt_cnt),
    .READY_OUT(rdy), .DECODE_VALID_OUT(dv), .OP_OUT(op_o),
    .WORDS_OUT(words_o), .CYCLES_OUT(cyc_o), .OPCODE_OUT(opc_o),
    .SECOND_WORD_OUT(w2_o), .INDIRECT_OUT(ind_o),
    .DIRECT_OFFSET_OUT(off_o), .IMMEDIATE_OUT(imm_o),
    .BIT_SELECT_CODE_OUT(bsel), .COND_TRUE_OUT(ctrue),
    .PRODUCT_SHIFT_WE_OUT(pswe), .PRODUCT_SHIFT_MODE_OUT(psm),
    .REPEAT_TOTAL_OUT(rtot), .EXEC_DONE_OUT(done));

  dcd_fetch_model u_dcd_fetch_model (
    .clk_in(clk), .rst_in(srst), .req_in(f_req), .slow_in(f_slow),
    .nwords_in(f_nw), .word1_in(f_w1), .word2_in(f_w2), .ready_in(rdy),
    .valid_out(word_valid), .word_out(word));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [16:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Sends one instruction and follows it through decode and execution.
  task automatic run(input logic [15:0] w1, w2, input dcd_op_type op,
                     input logic [1:0] nw, input logic [3:0] cyc,
                     input int waits);
    int n;
    logic we;
    f_w1 = w1;
    f_w2 = w2;
    f_nw = nw;
    f_req = 1'b1;
    @(posedge clk);
    #1 f_req = 1'b0;
    n = 0;
    while (dv !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    we = pswe;
    check("op", 17'(op_o), 17'(op));
    check("words", 17'(words_o), 17'(nw));
    check("cycles", 17'(cyc_o), 17'(cyc));
    check("opcode", 17'(opc_o), 17'(w1));
    check("second", 17'(w2_o), 17'(nw == 2'h2 ? w2 : 16'h0000));
    check("indirect", 17'(ind_o), 17'(w1[7]));
    check("offset", 17'(off_o), 17'(w1[6:0]));
    check("ready_busy", 17'(rdy), 17'h00000);
    check("shift_we", 17'(we), 17'(op == OP_SET_PRODUCT_SHIFT));
    wait_st = (waits > 0);
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
      if (n == waits) wait_st = 1'b0;
    end
    check("exec_span", 17'(n), 17'(cyc) + 17'(waits));
    @(posedge clk);
    #1 check("ready_back", 17'(rdy), 17'h00001);
  endtask

  task automatic r1(input logic [15:0] w, input dcd_op_type op,
                    input logic [3:0] c);
    run(w, 16'h0000, op, 2'h1, c, 0);
  endtask

  task automatic r2(input logic [15:0] w, input dcd_op_type op,
                    input logic [3:0] c);
    run(w, ~w, op, 2'h2, c, 0);
  endtask

  // Conditional transfer; the expected outcome is worked out here.
  task automatic cnd(input logic [1:0] k, sel, input logic [7:0] lo,
                     input logic p, t, input logic [3:0] fl);
    logic ok;
    dcd_op_type op;
    ok = (sel == 2'h0) ? !p : (sel == 2'h1) ? t :
         (sel == 2'h2) ? !t : 1'b1;
    ok = ok && (((fl ^ lo[7:4]) & lo[3:0]) == 4'h0);
    op = (k == 2'h0) ? OP_COND_BRANCH :
         (k == 2'h2) ? OP_COND_CALL : OP_COND_RETURN;
    pin = p;
    tc = t;
    flags = fl;
    run({4'he, k, sel, lo}, 16'h1234, op, (k == 2'h3) ? 2'h1 : 2'h2,
        ok ? 4'h4 : 4'h2, 0);
    check("cond", 17'(ctrue), 17'(ok));
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    srst = 1'b1;
    f_req = 1'b0;
    f_slow = 1'b0;
    f_nw = 2'h1;
    f_w1 = 16'h0000;
    f_w2 = 16'h0000;
    wait_st = 1'b0;
    pin = 1'b1;
    tc = 1'b0;
    flags = 4'h0;
    ar_nz = 1'b0;
    rpt_cnt = 16'h0000;
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    check("reset_op", 17'(op_o), 17'(OP_NONE));
    check("reset_dv", 17'(dv), 17'h00000);
    @(posedge clk);
    #1;
    r2(16'ha205, OP_MULT_ACCUM, 4'h3);
    f_slow = 1'b1;
    r2(16'ha385, OP_MULT_ACCUM_MOVE, 4'h3);
    f_slow = 1'b0;
    r1(16'h5410, OP_MULTIPLY, 4'h1);
    r1(16'h55ff, OP_UNSIGNED_MULTIPLY, 4'h1);
    r1(16'hc9ab, OP_MULTIPLY_K, 4'h1);
    check("imm_k", 17'(imm_o), 17'h009ab);
    r1(16'h5001, OP_MULTIPLY_ADD_PREV, 4'h1);
    r1(16'h5182, OP_MULTIPLY_SUB_PREV, 4'h1);
    r1(16'h5203, OP_SQUARE_ADD_PREV, 4'h1);
    r1(16'h5384, OP_SQUARE_SUB_PREV, 4'h1);
    r1(16'hbe03, OP_PRODUCT_TO_ACCUM, 4'h1);
    r1(16'hbe05, OP_SUB_PRODUCT, 4'h1);
    r1(16'h8d11, OP_STORE_PRODUCT_HIGH, 4'h1);
    r1(16'h8ca2, OP_STORE_PRODUCT_LOW, 4'h1);
    r1(16'hbf02, OP_SET_PRODUCT_SHIFT, 4'h1);
    check("shift_mode", 17'(psm), 17'h00002);
    r1(16'hbf01, OP_SET_PRODUCT_SHIFT, 4'h1);
    check("shift_mode", 17'(psm), 17'h00001);
    ar_nz = 1'b1;
    r2(16'h7b80, OP_BRANCH_AR_NONZERO, 4'h4);
    check("branch_ar_nonzero_op_cond", 17'(ctrue), 17'h00001);
    ar_nz = 1'b0;
    r2(16'h7b85, OP_BRANCH_AR_NONZERO, 4'h2);
    check("branch_ar_nonzero_op_cond", 17'(ctrue), 17'h00000);
    r1(16'h7b05, OP_NONE, 4'h1);
    r1(16'hbe20, OP_BRANCH_TO_ACCUM, 4'h4);
    r1(16'hbe30, OP_CALL_TO_ACCUM, 4'h4);
    r1(16'h4a33, OP_BIT_TEST, 4'h1);
    check("bit_code", 17'(bsel), 17'h0000a);
    r1(16'h6fc4, OP_TEMP_BIT_TEST, 4'h1);
    r1(16'h0d55, OP_LOAD_PAGE_PTR, 4'h2);
    check("plain_cond", 17'(ctrue), 17'h00001);
    r1(16'hbd23, OP_LOAD_PAGE_PTR_K, 4'h2);
    check("imm_page", 17'(imm_o), 17'h00123);
    r1(16'h0e66, OP_LOAD_STATUS0, 4'h2);
    r1(16'h0ff7, OP_LOAD_STATUS1, 4'h2);
    r1(16'h8e01, OP_STORE_STATUS0, 4'h1);
    r1(16'h8f82, OP_STORE_STATUS1, 4'h1);
    r1(16'hbe32, OP_STACK_POP_ACCUM, 4'h1);
    r1(16'hbe3c, OP_STACK_PUSH_ACCUM, 4'h1);
    r1(16'h8a03, OP_STACK_POP_MEM, 4'h1);
    r1(16'h7684, OP_STACK_PUSH_MEM, 4'h1);
    rpt_cnt = 16'hffff;
    r1(16'h0b05, OP_REPEAT_NEXT, 4'h1);
    check("rpt_mem", rtot, 17'h10000);
    r1(16'hbb0f, OP_REPEAT_NEXT_K, 4'h1);
    check("rpt_k", rtot, 17'h00010);
    r2(16'ha806, OP_DATA_BLOCK_MOVE_SRC, 4'h3);
    f_slow = 1'b1;
    r2(16'ha987, OP_DATA_BLOCK_MOVE_DST, 4'h3);
    f_slow = 1'b0;
    r2(16'ha508, OP_PROG_BLOCK_MOVE, 4'h3);
    r1(16'ha609, OP_TABLE_READ, 4'h3);
    r1(16'ha78a, OP_TABLE_WRITE, 4'h3);
    r2(16'haf0b, OP_IO_IN, 4'h2);
    r2(16'h0c8c, OP_IO_OUT, 4'h3);
    run(16'ha609, 16'h0000, OP_TABLE_READ, 2'h1, 4'h3, 2);
    run(16'h5410, 16'h0000, OP_MULTIPLY, 2'h1, 4'h1, 3);
    r1(16'hffff, OP_NONE, 4'h1);
    for (int k = 0; k < 4; k++) begin
      if (k != 1) begin
        for (int s = 0; s < 4; s++) begin
          cnd(2'(k), 2'(s), 8'h00, 1'b0, 1'b1, 4'h0);
          cnd(2'(k), 2'(s), 8'h00, 1'b1, 1'b0, 4'h0);
        end
        cnd(2'(k), 2'h3, 8'hc4, 1'b1, 1'b0, 4'h4);
        cnd(2'(k), 2'h3, 8'hc4, 1'b1, 1'b0, 4'hb);
        cnd(2'(k), 2'h3, 8'h1f, 1'b1, 1'b0, 4'h1);
        cnd(2'(k), 2'h0, 8'h1f, 1'b1, 1'b0, 4'h1);
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
